// >>> ctr_link_if.sv
// Interface: configuration, event inputs and results between control and one counter.
// Assumes one core clock shared by both ends.
`timescale 1ns/1ps
interface ctr_link_if;
  import perf_evsel_pkg::*;
  logic [31:0] sel;
  logic gen_en;
  logic [NUM_EV*UNIT_W-1:0] ev_units;
  logic [1:0] cpl;
  logic wr_en;
  logic [CTR_W-1:0] wr_data;
  logic [CTR_W-1:0] cnt;
  logic ovf;
  modport ctl (output sel, gen_en, ev_units, cpl, wr_en, wr_data, input cnt, ovf);
  modport unit (input sel, gen_en, ev_units, cpl, wr_en, wr_data, output cnt, ovf);
endinterface : ctr_link_if

// >>> perf_ctr_unit.sv
// One performance counter steered by its event-select word.
// Assumes events are unit bit vectors sampled each core clock.
`timescale 1ns/1ps
module perf_ctr_unit
  import perf_evsel_pkg::*;
(
  // Clock and reset
  input logic i_core_clk,
  input logic i_srst,
  // Link to control
  ctr_link_if.unit lnk
);
  function automatic logic [NCNT_W-1:0] popcnt(input logic [UNIT_W-1:0] v);
    logic [NCNT_W-1:0] s;
    s = '0;
    for (int k = 0; k < UNIT_W; k++) begin
      s = s + {{(NCNT_W-1){1'b0}}, v[k]};
    end
    return s;
  endfunction : popcnt

  logic [CTR_W-1:0] cnt_r;
  logic pass_q_r;

  wire [EVT_W-1:0] code = lnk.sel[EVT_LSB +: EVT_W];
  wire [QUAL_W-1:0] qual_raw = lnk.sel[QUAL_LSB +: QUAL_W];
  wire [THR_W-1:0] thr = lnk.sel[THR_LSB +: THR_W];
  wire code_ok = (code < EVT_W'(NUM_EV));
  wire [UNIT_W-1:0] units = lnk.ev_units[code[EVSEL_W-1:0]*UNIT_W +: UNIT_W];
  wire [QUAL_W-1:0] qual = (qual_raw == '0) ? '1 : qual_raw;
  wire [NCNT_W-1:0] n = code_ok ? popcnt(units & qual) : '0;
  wire thr_on = (thr != '0);
  wire cmp = ({{(THR_W-NCNT_W){1'b0}}, n} >= thr) ^ lnk.sel[INV_BIT];
  wire pass = thr_on ? cmp : (n != '0);
  wire priv_ok = (lnk.cpl == CPL_KERNEL) ? lnk.sel[KRN_BIT] : lnk.sel[USR_BIT];
  wire active = lnk.gen_en & priv_ok & code_ok;
  // Occurrence with a threshold counts entries into the passing state
  wire [NCNT_W-1:0] inc_occ = thr_on ? {{(NCNT_W-1){1'b0}}, pass & ~pass_q_r} : n;
  wire [NCNT_W-1:0] inc_dur = {{(NCNT_W-1){1'b0}}, pass};
  wire [NCNT_W-1:0] inc = !active ? '0 : (lnk.sel[OCC_BIT] ? inc_occ : inc_dur);
  wire [CTR_W:0] sum = {1'b0, cnt_r} + {{(CTR_W+1-NCNT_W){1'b0}}, inc};

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cnt_r <= RST_CTR;
      pass_q_r <= 1'b0;
    end else begin
      // Software write wins over counting in the same cycle
      cnt_r <= lnk.wr_en ? lnk.wr_data : sum[CTR_W-1:0];
      pass_q_r <= active & pass;
    end
  end

  assign lnk.cnt = cnt_r;
  assign lnk.ovf = ~lnk.wr_en & sum[CTR_W];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  property p_gen_off;
    !lnk.gen_en && !lnk.wr_en |=> lnk.cnt == $past(lnk.cnt);
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("count moved while disabled");
  property p_priv;
    lnk.cpl == CPL_KERNEL && !lnk.sel[KRN_BIT] && !lnk.wr_en |=> $stable(lnk.cnt);
  endproperty
  a_priv: assert property (p_priv) else $error("kernel count without enable");
  property p_occ;
    active && lnk.sel[OCC_BIT] && !thr_on && !lnk.wr_en
      |=> lnk.cnt == CTR_W'($past(lnk.cnt) + {28'h0, $past(n)});
  endproperty
  a_occ: assert property (p_occ) else $error("occurrence sum wrong");
  property p_dur;
    active && !lnk.sel[OCC_BIT] && pass && !lnk.wr_en |=> lnk.cnt == $past(lnk.cnt) + 32'h1;
  endproperty
  a_dur: assert property (p_dur) else $error("duration step wrong");
  property p_thr;
    thr_on && !lnk.sel[INV_BIT] && ({4'h0, n} < thr) && !lnk.wr_en |=> $stable(lnk.cnt);
  endproperty
  a_thr: assert property (p_thr) else $error("counted below threshold");
  property p_inv;
    thr_on && lnk.sel[INV_BIT] && ({4'h0, n} < thr) |-> pass;
  endproperty
  a_inv: assert property (p_inv) else $error("inverted compare failed");
  property p_code;
    !code_ok && !lnk.wr_en |=> $stable(lnk.cnt);
  endproperty
  a_code: assert property (p_code) else $error("unsupported event counted");
  c_occ_edge: cover property (active && lnk.sel[OCC_BIT] && thr_on && pass ##1 !pass ##1 pass);
endmodule : perf_ctr_unit

// >>> perf_event_select_ctl.sv
// Top: event-select registers, two counters, overflow pin and interrupt request.
// Assumes a single-cycle strobe register port and synchronous event inputs.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Bit 18 one counts occurrences, zero counts active cycles.
// - Bit 19 makes a counter overflow pulse the breakpoint pin zero.
// - Bit 20 lets a counter overflow request the local interrupt controller.
// - Bit 23 inverts the threshold compare against bits 31:24.
// - Bits 7:0 pick the event the counter watches.
// - Bits 15:8 qualify event units; zero takes every unit.
// - Bit 16 enables user levels, bit 17 enables kernel level.
// - Bit 22 of the first select word enables both counters.
module perf_event_select_ctl
  import perf_evsel_pkg::*;
(
  // Clock and reset
  input logic i_core_clk,
  input logic i_srst,
  // Register port
  input logic [ADDR_W-1:0] i_addr,
  input logic [31:0] i_wdata,
  input logic i_wr,
  input logic i_rd,
  output logic [31:0] o_rdata,
  // Events and privilege
  input logic [NUM_EV*UNIT_W-1:0] i_event_units,
  input logic [1:0] i_cpl,
  // Signalling
  output logic o_breakpoint_pin_zero,
  output logic o_local_interrupt_controller_irq
);
  logic [31:0] sel_r [NUM_CTR];
  logic [NUM_CTR-1:0] stat_r;
  logic [NUM_CTR-1:0] mask_r;
  logic [31:0] rdata_r;
  logic bp_r;
  logic irq_r;
  logic [NUM_CTR-1:0] ovf;
  logic [NUM_CTR-1:0] pin_ev;
  logic [NUM_CTR-1:0] int_ev;
  logic [CTR_W-1:0] cnt [NUM_CTR];

  wire word_ok = (i_addr[1:0] == 2'h0);
  wire [9:0] idx = i_addr[ADDR_W-1:2];
  wire hit_sel0 = word_ok && (idx == IDX_SEL0);
  wire hit_sel1 = word_ok && (idx == IDX_SEL1);
  wire hit_ctr0 = word_ok && (idx == IDX_CTR0);
  wire hit_ctr1 = word_ok && (idx == IDX_CTR1);
  wire hit_stat = word_ok && (idx == IDX_STAT);
  wire hit_mask = word_ok && (idx == IDX_MASK);
  wire [NUM_CTR-1:0] hit_sel = {hit_sel1, hit_sel0};
  wire [NUM_CTR-1:0] hit_ctr = {hit_ctr1, hit_ctr0};
  wire rd_stat = i_rd && hit_stat;
  wire gen_en = sel_r[0][GEN_BIT];

  genvar g;
  generate
    for (g = 0; g < NUM_CTR; g++) begin : g_ctr
      ctr_link_if lnk ();
      assign lnk.sel = sel_r[g];
      assign lnk.gen_en = gen_en;
      assign lnk.ev_units = i_event_units;
      assign lnk.cpl = i_cpl;
      assign lnk.wr_en = i_wr && hit_ctr[g];
      assign lnk.wr_data = i_wdata;
      assign cnt[g] = lnk.cnt;
      assign ovf[g] = lnk.ovf;
      assign pin_ev[g] = lnk.ovf & sel_r[g][PIN_BIT];
      assign int_ev[g] = lnk.ovf & sel_r[g][INT_BIT];
      perf_ctr_unit u_ctr (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .lnk(lnk)
      );
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          sel_r[g] <= RST_SEL;
        end else if (i_wr && hit_sel[g]) begin
          sel_r[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // Set wins over the read that clears, so no overflow is lost
  wire [NUM_CTR-1:0] stat_nxt = (rd_stat ? '0 : stat_r) | int_ev;
  wire [NUM_CTR-1:0] mask_nxt = (i_wr && hit_mask) ? i_wdata[NUM_CTR-1:0] : mask_r;
  wire [31:0] rd_word =
      hit_sel0 ? sel_r[0] :
      hit_sel1 ? sel_r[1] :
      hit_ctr0 ? cnt[0] :
      hit_ctr1 ? cnt[1] :
      hit_stat ? {30'h0, stat_r} :
      hit_mask ? {30'h0, mask_r} : 32'h0;
  wire [31:0] rdata_nxt = i_rd ? rd_word : 32'h0;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      stat_r <= RST_STAT;
      mask_r <= RST_MASK;
      rdata_r <= 32'h0;
      bp_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      bp_r <= |pin_ev;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  assign o_rdata = rdata_r;
  assign o_breakpoint_pin_zero = bp_r;
  assign o_local_interrupt_controller_irq = irq_r;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  property p_pin;
    |pin_ev |=> o_breakpoint_pin_zero;
  endproperty
  a_pin: assert property (p_pin) else $error("overflow pin missed");
  property p_pin_quiet;
    !(|pin_ev) |=> !o_breakpoint_pin_zero;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet) else $error("spurious overflow pin");
  property p_int_set;
    int_ev[0] |=> stat_r[0];
  endproperty
  a_int_set: assert property (p_int_set) else $error("overflow status lost");
  property p_int_off;
    ovf[1] && !sel_r[1][INT_BIT] && !stat_r[1] |=> !stat_r[1];
  endproperty
  a_int_off: assert property (p_int_off) else $error("status set with request off");
  property p_irq_lvl;
    ##1 o_local_interrupt_controller_irq == |(stat_r & mask_r);
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("irq level mismatch");
  property p_rd_clr;
    rd_stat && !(|int_ev) |=> stat_r == '0 ##1 1'b1;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("status not cleared on read");
  property p_rd_sel1;
    i_rd && hit_sel1 |=> o_rdata == $past(sel_r[1]);
  endproperty
  a_rd_sel1: assert property (p_rd_sel1) else $error("select read wrong");
  c_ovf: cover property (|ovf);
  c_irq: cover property (int_ev[1] ##[1:20] o_local_interrupt_controller_irq);
  c_clear: cover property (o_local_interrupt_controller_irq ##1 rd_stat ##1 !irq_r);
endmodule : perf_event_select_ctl

// >>> perf_event_select_ctl_test.sv
// Testbench: drives the register port and event inputs, checks counts and signalling.
// Assumes the design top without parameters and a 200 MHz core clock.
`timescale 1ns/1ps
module perf_event_select_ctl_test;
  import perf_evsel_pkg::*;
  typedef struct packed {
    logic g;
    logic [1:0] cpl;
    logic [31:0] sel;
    logic [31:0] exp;
  } row_t;
  localparam logic [ADDR_W-1:0] A_SEL0 = {IDX_SEL0, 2'h0};
  localparam logic [ADDR_W-1:0] A_SEL1 = {IDX_SEL1, 2'h0};
  localparam logic [ADDR_W-1:0] A_CTR0 = {IDX_CTR0, 2'h0};
  localparam logic [ADDR_W-1:0] A_CTR1 = {IDX_CTR1, 2'h0};
  localparam logic [ADDR_W-1:0] A_STAT = {IDX_STAT, 2'h0};
  localparam logic [ADDR_W-1:0] A_MASK = {IDX_MASK, 2'h0};
  logic i_core_clk, i_srst, i_wr, i_rd, bp, irq;
  logic [ADDR_W-1:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [63:0] ev;
  logic [1:0] cpl;
  int n_fail = 0;
  int num_checks = 0;
  int pins;
  // Each row runs ten sampled cycles; event 3 has four units, event 2 all eight
  row_t rows [16] = '{
    '{1'b1, 2'h0, 32'h0007_0003, 32'h0000_0028},
    '{1'b1, 2'h0, 32'h0003_0003, 32'h0000_000a},
    '{1'b1, 2'h0, 32'h0083_0003, 32'h0000_000a},
    '{1'b1, 2'h0, 32'h0007_0002, 32'h0000_0050},
    '{1'b1, 2'h0, 32'h0007_0f02, 32'h0000_0028},
    '{1'b1, 2'h0, 32'h0007_0008, 32'h0000_0000},
    '{1'b1, 2'h0, 32'h0005_0003, 32'h0000_0000},
    '{1'b1, 2'h3, 32'h0005_0003, 32'h0000_0028},
    '{1'b1, 2'h0, 32'h0006_0003, 32'h0000_0028},
    '{1'b1, 2'h2, 32'h0006_0003, 32'h0000_0000},
    '{1'b1, 2'h0, 32'h0403_0003, 32'h0000_000a},
    '{1'b1, 2'h0, 32'h0503_0003, 32'h0000_0000},
    '{1'b1, 2'h0, 32'h0583_0003, 32'h0000_000a},
    '{1'b1, 2'h0, 32'h0483_0003, 32'h0000_0000},
    '{1'b1, 2'h0, 32'h0407_0003, 32'h0000_0001},
    '{1'b0, 2'h0, 32'h0007_0003, 32'h0000_0000}
  };

  perf_event_select_ctl dut_u (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_event_units(ev),
    .i_cpl(cpl),
    .o_breakpoint_pin_zero(bp),
    .o_local_interrupt_controller_irq(irq)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic final_report;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Strobe stays one cycle; the spare cycle keeps a strobe from being driven twice per step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
    @(posedge i_core_clk);
    #1 chk(o_rdata, 32'h0);
    @(posedge i_core_clk);
  endtask : rd

  // Counter 1 starts eight counts short of its carry
  task automatic ovf(input logic [31:0] sel, input logic [31:0] mask, input logic [31:0] stat,
                     input int npin, input logic irq_exp);
    wr(A_MASK, mask);
    wr(A_CTR1, 32'hffff_fff8);
    wr(A_SEL1, sel);
    pins = 0;
    repeat (16) begin
      #1 pins += int'(bp);
      @(posedge i_core_clk);
    end
    chk(32'(pins), 32'(npin));
    #1 chk({31'h0, irq}, {31'h0, irq_exp});
    @(posedge i_core_clk);
    wr(A_SEL1, 32'h0);
    rd(A_STAT, stat);
    rd(A_STAT, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge i_core_clk);
  endtask : ovf

  initial begin
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    ev = 64'h0000_0000_0fff_0000;
    cpl = 2'h0;
    repeat (4) @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    #1 chk({30'h0, bp, irq}, 32'h0);
    @(posedge i_core_clk);
    for (int i = 0; i < 6; i++) rd(A_SEL0 + 12'(4 * i), 32'h0);
    foreach (rows[i]) begin
      wr(A_SEL0, 32'(rows[i].g) << GEN_BIT);
      cpl <= rows[i].cpl;
      wr(A_CTR1, 32'h0);
      wr(A_SEL1, rows[i].sel);
      repeat (8) @(posedge i_core_clk);
      wr(A_SEL1, 32'h0);
      rd(A_CTR1, rows[i].exp);
    end
    cpl <= 2'h0;
    wr(A_SEL1, 32'ha5c3_1234);
    rd(A_SEL1, 32'ha5c3_1234);
    wr(A_SEL1, 32'h0);
    wr(12'h700, 32'hffff_ffff);
    rd(12'h700, 32'h0);
    wr(A_SEL1 | 12'h1, 32'hffff_ffff);
    rd(A_SEL1, 32'h0);
    wr(A_MASK, 32'hffff_ffff);
    rd(A_MASK, 32'h3);
    // Counter 0 follows its own word under the same global enable
    wr(A_CTR0, 32'h0);
    wr(A_SEL0, 32'h0043_0003);
    repeat (8) @(posedge i_core_clk);
    wr(A_SEL0, 32'h0040_0000);
    rd(A_CTR0, 32'h0000_000a);
    ovf(32'h001b_0003, 32'h2, 32'h2, 1, 1'b1);
    ovf(32'h0003_0003, 32'h2, 32'h0, 0, 1'b0);
    ovf(32'h0013_0003, 32'h0, 32'h2, 0, 1'b0);
    wr(A_SEL1, 32'h0007_0003);
    i_srst <= 1'b1;
    @(posedge i_core_clk);
    i_srst <= 1'b0;
    @(posedge i_core_clk);
    rd(A_SEL1, 32'h0);
    rd(A_SEL0, 32'h0);
    final_report;
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    final_report;
  end
endmodule : perf_event_select_ctl_test

// >>> perf_evsel_pkg.sv
// Package: field layout, register indices and sizes of the event-select block.
// Assumes 32-bit register words reached by byte address = 4 * index.
package perf_evsel_pkg;
  localparam int NUM_CTR = 2;
  localparam int NUM_EV = 8;
  localparam int UNIT_W = 8;
  localparam int CTR_W = 32;
  localparam int ADDR_W = 12;
  localparam int EVSEL_W = 3;
  localparam int NCNT_W = 4;
  // Field positions inside each event-select word
  localparam int EVT_LSB = 0;
  localparam int EVT_W = 8;
  localparam int QUAL_LSB = 8;
  localparam int QUAL_W = 8;
  localparam int USR_BIT = 16;
  localparam int KRN_BIT = 17;
  localparam int OCC_BIT = 18;
  localparam int PIN_BIT = 19;
  localparam int INT_BIT = 20;
  localparam int GEN_BIT = 22;
  localparam int INV_BIT = 23;
  localparam int THR_LSB = 24;
  localparam int THR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_SEL0 = 10'h186;
  localparam logic [9:0] IDX_SEL1 = 10'h187;
  localparam logic [9:0] IDX_CTR0 = 10'h188;
  localparam logic [9:0] IDX_CTR1 = 10'h189;
  localparam logic [9:0] IDX_STAT = 10'h18a;
  localparam logic [9:0] IDX_MASK = 10'h18b;
  // Reset values
  localparam logic [31:0] RST_SEL = 32'h0000_0000;
  localparam logic [CTR_W-1:0] RST_CTR = 32'h0000_0000;
  localparam logic [NUM_CTR-1:0] RST_STAT = 2'h0;
  localparam logic [NUM_CTR-1:0] RST_MASK = 2'h0;
  localparam logic [1:0] CPL_KERNEL = 2'h0;
endpackage : perf_evsel_pkg
